/* core/adcsq_defs.vh */
// constants for the converter sequencer control block
`ifndef ADCSQ_DEFS_VH
`define ADCSQ_DEFS_VH
`define ADCSQ_OFF_CTRL      8'h00
`define ADCSQ_OFF_DATA      8'h04
`define ADCSQ_OFF_STAT      8'h08
`define ADCSQ_OFF_CONV      8'h0c
`define ADCSQ_OFF_SEQC      8'h10
`define ADCSQ_OFF_SSTAT     8'h14
`define ADCSQ_OFF_TIME      8'h18
`define ADCSQ_OFF_MISC      8'h1c
`define ADCSQ_ST_CBUSY      0
`define ADCSQ_ST_SBUSY      1
`define ADCSQ_ST_CIRQ       2
`define ADCSQ_ST_SIRQ       3
`define ADCSQ_SC_RUN        0
`define ADCSQ_SC_TRIG       1
`define ADCSQ_SC_IEN        2
`define ADCSQ_SS_DAV        0
`define ADCSQ_SS_OVF        1
`define ADCSQ_SS_TERR       2
`define ADCSQ_SS_IERR       3
`define ADCSQ_SS_IRQ        4
`define ADCSQ_MS_MIE        0
`define ADCSQ_MS_AUTOMATIC_SETTLING_CONTROL       1
`define ADCSQ_MS_TOUT       2
`define ADCSQ_MS_IRAM       3
`define ADCSQ_SETTLE_NS     16000
`define ADCSQ_CLK_NS        100
`define ADCSQ_ZERO32        32'h0000_0000
`endif

/* core/adcsq_ctrl.v */
// converter status, conversion start and sequencer control logic
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "adcsq_defs.vh"
module adcsq_ctrl #(
    parameter CONV_CYCLES  = 40,
    parameter SEQ_CYCLES   = 200,
    parameter TICK_CYCLES  = 1000
) (
    // clock and reset
    input  wire        mclk_i,
    input  wire        rstn_i,
    // register port
    input  wire [7:0]  addr_i,
    input  wire [31:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [31:0] rdata_o,
    // converter side
    input  wire [15:0] conv_data_i,
    input  wire        ext_trig_i,
    output reg  [7:0]  chan_gain_o,
    output reg         conv_start_o,
    output reg         trig_o,
    output reg         trig_oe_n_o,
    output reg         irq_o
);
    localparam SETTLE_CYC = (`ADCSQ_SETTLE_NS + `ADCSQ_CLK_NS - 1) / `ADCSQ_CLK_NS;
    localparam SEQ_IDLE = 2'd0;
    localparam SEQ_RUN  = 2'd1;
    localparam SEQ_STOP = 2'd2;

    // software visible channel, result and status state, with the internal conversion and auto start flags
    reg  [7:0]  ctrl_r;
    reg  [15:0] data_r;
    reg         sirq_r;
    reg         cirq_r;
    reg         sbusy_r;
    reg         cbusy_r;
    reg         conv_seq_r;
    reg         auto_pend_r;

    // sequencer control, status, timer and misc state
    reg  [2:0]  seqc_r;
    reg  [3:0]  ss_r;
    reg  [15:0] time_r;
    reg  [3:0]  misc_r;

    // interval counters and sequence state
    reg  [15:0] settle_cnt_r;
    reg  [15:0] conv_cnt_r;
    reg  [15:0] seq_cnt_r;
    reg  [15:0] tick_cnt_r;
    reg  [15:0] tmr_r;
    reg  [1:0]  seq_st_r;

    // external trigger synchroniser stages
    reg         ext_s1_r;
    reg         ext_s2_r;
    reg         ext_s3_r;

    // register map of the window, all words 32 bits wide
    // 0x00 channel and gain, low byte, locked while settling
    // 0x04 conversion result, low half, read only
    // 0x08 status: settle pending, conversion pending, busy flags
    // 0x0c conversion start, any data, write only
    // 0x10 sequencer control: irq enable, trigger select, run
    // 0x14 sequencer status, flags cleared by writing ones
    // 0x18 sequencer timer preload, zero selects continuous mode
    // 0x1c misc: master irq enable, auto settling, trigger out
    // unmapped reads return zero, unmapped writes are dropped
    // narrow registers sit in the low bits of the word

    // write strobe decode
    function wsel;
        input [7:0] off;
        begin
            wsel = wr_i && (addr_i == off);
        end
    endfunction

    wire w_ctrl = wsel(`ADCSQ_OFF_CTRL);
    wire w_stat = wsel(`ADCSQ_OFF_STAT);
    wire w_conv = wsel(`ADCSQ_OFF_CONV);
    wire w_seqc = wsel(`ADCSQ_OFF_SEQC);
    wire w_ss   = wsel(`ADCSQ_OFF_SSTAT);
    wire w_time = wsel(`ADCSQ_OFF_TIME);
    wire w_misc = wsel(`ADCSQ_OFF_MISC);

    // start, end and trigger qualifiers shared by the processes
    // every counter ends on one, so a load of n gives n cycles
    wire ctrl_take  = w_ctrl && !sbusy_r;
    wire settle_end = sbusy_r && (settle_cnt_r == 16'h0001);
    wire conv_end   = cbusy_r && (conv_cnt_r == 16'h0001);
    wire man_start  = w_conv && !misc_r[`ADCSQ_MS_AUTOMATIC_SETTLING_CONTROL] && !seqc_r[`ADCSQ_SC_RUN];
    wire auto_start = auto_pend_r && settle_end && !seqc_r[`ADCSQ_SC_RUN];
    wire ext_edge   = ext_s2_r && !ext_s3_r;
    wire tick       = (tick_cnt_r == 16'h0001);
    wire cont_mode  = (time_r == 16'h0000);
    wire tmr_fire   = !cont_mode && tick && (tmr_r == 16'h0001);
    wire trig_int   = tmr_fire;
    wire sequence_trigger_select   = seqc_r[`ADCSQ_SC_TRIG] ? ext_edge : trig_int;
    wire seq_done   = (seq_st_r == SEQ_RUN) && (seq_cnt_r == 16'h0001);
    wire err_any    = ss_r[`ADCSQ_SS_OVF] | ss_r[`ADCSQ_SS_TERR] | ss_r[`ADCSQ_SS_IERR];
    wire seq_irq    = seqc_r[`ADCSQ_SC_IEN] && (err_any ||
                      (ss_r[`ADCSQ_SS_DAV] && !cont_mode));

    // external trigger synchroniser and edge register
    // the line is asynchronous, so two stages guard metastability
    // the third stage only remembers the last settled level
    // a line held high gives one edge and so one start request
    // reset level matches the idle low line, no false edge
    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
        end else begin
            ext_s1_r <= ext_trig_i;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    // channel and gain control with settling timer
    // a write while settling is dropped so the interval restarts never
    // the converter keeps the old setting for a running conversion
    // auto settling mode is latched at the write, not at the end
    // busy falls exactly one interval after the accepted write
    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            ctrl_r       <= 8'h00;
            sbusy_r      <= 1'b0;
            settle_cnt_r <= 16'h0000;
            auto_pend_r  <= 1'b0;
        end else if (ctrl_take) begin
            ctrl_r       <= wdata_i[7:0];
            sbusy_r      <= 1'b1;
            settle_cnt_r <= SETTLE_CYC[15:0];
            auto_pend_r  <= misc_r[`ADCSQ_MS_AUTOMATIC_SETTLING_CONTROL];
        end else if (sbusy_r) begin
            settle_cnt_r <= settle_cnt_r - 16'h0001;
            if (settle_end) begin
                sbusy_r     <= 1'b0;
                auto_pend_r <= 1'b0;
            end
        end
    end

    // conversion engine shared by manual and automatic starts
    // a start while busy is dropped, one conversion at a time
    // the start pulse lasts one cycle toward the converter
    // result is captured on the falling edge of conversion busy
    // conv_seq_r is never set, so every conversion writes the result register
    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            cbusy_r      <= 1'b0;
            conv_cnt_r   <= 16'h0000;
            conv_seq_r   <= 1'b0;
            data_r       <= 16'h0000;
            conv_start_o <= 1'b0;
        end else begin
            conv_start_o <= 1'b0;
            if (!cbusy_r && (man_start || auto_start)) begin
                cbusy_r      <= 1'b1;
                conv_cnt_r   <= CONV_CYCLES[15:0];
                conv_seq_r   <= 1'b0;
                conv_start_o <= 1'b1;
            end else if (cbusy_r) begin
                conv_cnt_r <= conv_cnt_r - 16'h0001;
                if (conv_end) begin
                    cbusy_r <= 1'b0;
                    if (!conv_seq_r)
                        data_r <= conv_data_i;
                end
            end
        end
    end

    // pending flags, hardware set wins over software acknowledge
    // an acknowledge in the event cycle would otherwise lose an event
    // writing zero to a pending bit leaves it untouched
    // reserved status bits have no storage at all
    // both flags feed the host request through the master enable
    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            sirq_r <= 1'b0;
            cirq_r <= 1'b0;
        end else begin
            if (settle_end)
                sirq_r <= 1'b1;
            else if (w_stat && wdata_i[`ADCSQ_ST_SIRQ])
                sirq_r <= 1'b0;
            if (conv_end)
                cirq_r <= 1'b1;
            else if (w_stat && wdata_i[`ADCSQ_ST_CIRQ])
                cirq_r <= 1'b0;
        end
    end

    // sequencer timer prescaler and countdown
    // the prescaler runs free and gives one tick per timer step
    // the countdown is reloaded while run is clear or in continuous mode
    // a firing timer is the internal trigger, also sent to the line
    // a shorter tick in simulation keeps runs short
    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            tick_cnt_r <= TICK_CYCLES[15:0];
            tmr_r      <= 16'h0000;
        end else begin
            tick_cnt_r <= tick ? TICK_CYCLES[15:0] : tick_cnt_r - 16'h0001;
            if (!seqc_r[`ADCSQ_SC_RUN] || cont_mode)
                tmr_r <= time_r;
            else if (tick)
                tmr_r <= (tmr_r == 16'h0001) ? time_r : tmr_r - 16'h0001;
        end
    end

    // sequencer control, status flags and sequence state machine
    // idle waits for run, running counts out one sequence
    // stopped waits for the selected trigger before the next one
    // any error ends the sequence at its end and clears run
    // in continuous mode a cleared run stops the sequence at once
    // flag sets come after the clear so hardware wins a tie
    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            seqc_r    <= 3'b000;
            ss_r      <= 4'h0;
            seq_st_r  <= SEQ_IDLE;
            seq_cnt_r <= 16'h0000;
        end else begin
            if (w_ss)
                ss_r <= ss_r & ~wdata_i[3:0];
            if (w_seqc)
                seqc_r <= wdata_i[2:0];
            case (seq_st_r)
                SEQ_IDLE: begin
                    if (w_seqc && wdata_i[`ADCSQ_SC_RUN]) begin
                        if (!misc_r[`ADCSQ_MS_IRAM]) begin
                            ss_r[`ADCSQ_SS_IERR] <= 1'b1;
                            seqc_r[`ADCSQ_SC_RUN] <= 1'b0;
                        end else begin
                            seq_st_r  <= SEQ_RUN;
                            seq_cnt_r <= SEQ_CYCLES[15:0];
                        end
                    end
                end
                SEQ_RUN: begin
                    if (sequence_trigger_select && !cont_mode)
                        ss_r[`ADCSQ_SS_TERR] <= 1'b1;
                    if (!seqc_r[`ADCSQ_SC_RUN] && cont_mode) begin
                        seq_st_r <= SEQ_IDLE;
                    end else if (seq_done) begin
                        if (!seqc_r[`ADCSQ_SC_RUN] || err_any) begin
                            seq_st_r <= SEQ_IDLE;
                            seqc_r[`ADCSQ_SC_RUN] <= 1'b0;
                        end else begin
                            if (ss_r[`ADCSQ_SS_DAV] && !cont_mode)
                                ss_r[`ADCSQ_SS_OVF] <= 1'b1;
                            ss_r[`ADCSQ_SS_DAV] <= 1'b1;
                            if (cont_mode) begin
                                seq_cnt_r <= SEQ_CYCLES[15:0];
                            end else begin
                                seq_st_r <= SEQ_STOP;
                            end
                        end
                    end else begin
                        seq_cnt_r <= seq_cnt_r - 16'h0001;
                    end
                end
                SEQ_STOP: begin
                    if (!seqc_r[`ADCSQ_SC_RUN] || err_any) begin
                        seq_st_r <= SEQ_IDLE;
                        seqc_r[`ADCSQ_SC_RUN] <= 1'b0;
                    end else if (sequence_trigger_select) begin
                        seq_st_r  <= SEQ_RUN;
                        seq_cnt_r <= SEQ_CYCLES[15:0];
                    end
                end
                default: seq_st_r <= SEQ_IDLE;
            endcase
        end
    end

    // timer preload and miscellaneous control
    // the misc word stands in for the interrupt and line registers
    // its instruction store bit models a non empty instruction memory
    // without it a run request raises the instruction error
    // the preload takes effect on the next timer reload
    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            time_r <= 16'h0000;
            misc_r <= 4'h0;
        end else begin
            if (w_time)
                time_r <= wdata_i[15:0];
            if (w_misc)
                misc_r <= wdata_i[3:0];
        end
    end

    // registered outputs toward converter, line and host
    // every output comes from a flip flop, one cycle behind its source
    // the line enable is low while the trigger is driven out
    // external trigger with output enabled would lock the sequencer
    // the host request is a level, held until the flags are cleared
    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            chan_gain_o <= 8'h00;
            trig_o      <= 1'b0;
            trig_oe_n_o <= 1'b1;
            irq_o       <= 1'b0;
        end else begin
            chan_gain_o <= ctrl_r;
            trig_o      <= trig_int;
            trig_oe_n_o <= !misc_r[`ADCSQ_MS_TOUT];
            irq_o       <= misc_r[`ADCSQ_MS_MIE] && (sirq_r || cirq_r || seq_irq);
        end
    end

    // read data, one cycle after the read strobe
    // data stand for one cycle only and read zero otherwise
    // overflow and trigger error flags read zero in continuous mode as they are inactive
    // the sequencer request bit is read only
    // reserved bits are filled with constant zeros
    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            rdata_o <= `ADCSQ_ZERO32;
        end else if (rd_i) begin
            if (addr_i == `ADCSQ_OFF_CTRL)
                rdata_o <= {24'h00_0000, ctrl_r};
            else if (addr_i == `ADCSQ_OFF_DATA)
                rdata_o <= {16'h0000, data_r};
            else if (addr_i == `ADCSQ_OFF_STAT)
                rdata_o <= {28'h000_0000, sirq_r, cirq_r, sbusy_r, cbusy_r};
            else if (addr_i == `ADCSQ_OFF_SEQC)
                rdata_o <= {29'h0000_0000, seqc_r};
            else if (addr_i == `ADCSQ_OFF_SSTAT)
                rdata_o <= {27'h000_0000, seq_irq, ss_r[3],
                            ss_r[2] & !cont_mode, ss_r[1] & !cont_mode, ss_r[0]};
            else if (addr_i == `ADCSQ_OFF_TIME)
                rdata_o <= {16'h0000, time_r};
            else if (addr_i == `ADCSQ_OFF_MISC)
                rdata_o <= {28'h000_0000, misc_r};
            else
                rdata_o <= `ADCSQ_ZERO32;
        end else begin
            rdata_o <= `ADCSQ_ZERO32;
        end
    end
endmodule // adcsq_ctrl

/* test/adcsq_ctrl_properties.sv */
// port-level assertion checker for the converter control block
`timescale 1ns/1ps
module adcsq_ctrl_props (
    // clock and reset
    input wire        mclk_i,
    input wire        rstn_i,
    // register port
    input wire [7:0]  addr_i,
    input wire [31:0] wdata_i,
    input wire        wr_i,
    input wire        rd_i,
    input wire [31:0] rdata_o,
    // converter side
    input wire        conv_start_o,
    input wire        trig_oe_n_o,
    input wire        irq_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    reg mie_r;
    reg toe_r;
    // shadow of the enables last written to the misc register
    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            mie_r <= 1'b0;
            toe_r <= 1'b0;
        end else if (wr_i && addr_i == 8'h1c) begin
            mie_r <= wdata_i[0];
            toe_r <= wdata_i[2];
        end
    end
    property p_resv; (rd_i && addr_i == 8'h08) |=> !(|rdata_o[31:4]); endproperty
    a_resv: assert property (p_resv) else $error("status reserved bits not zero");
    property p_seqc; (rd_i && addr_i == 8'h10) |=> !(|rdata_o[31:3]); endproperty
    a_seqc: assert property (p_seqc) else $error("sequencer control reserved bits not zero");
    property p_rst; $rose(rstn_i) |-> !irq_o && !conv_start_o && trig_oe_n_o && !(|rdata_o); endproperty
    a_rst: assert property (p_rst) else $error("outputs not at reset values");
    property p_once; conv_start_o |=> !conv_start_o [*8]; endproperty
    a_once: assert property (p_once) else $error("second start during conversion");
    property p_cbusy; conv_start_o ##1 (rd_i && addr_i == 8'h08) |=> rdata_o[0]; endproperty
    a_cbusy: assert property (p_cbusy) else $error("conversion busy not set");
    property p_sbusy; (wr_i && addr_i == 8'h00) ##2 (rd_i && addr_i == 8'h08) |=> rdata_o[1]; endproperty
    a_sbusy: assert property (p_sbusy) else $error("settle busy not set");
    property p_mie; !mie_r [*3] |-> !irq_o; endproperty
    a_mie: assert property (p_mie) else $error("interrupt without master enable");
    property p_toe_on; toe_r [*3] |-> !trig_oe_n_o; endproperty
    a_toe_on: assert property (p_toe_on) else $error("trigger line not driven");
    property p_toe_off; !toe_r [*3] |-> trig_oe_n_o; endproperty
    a_toe_off: assert property (p_toe_off) else $error("trigger line driven while off");
endmodule // adcsq_ctrl_props

/* test/adcsq_conv_model.sv */
// behavioural model of the converter chip behind the block
`timescale 1ns/1ps
module adcsq_conv_model (
    // clock
    input  wire        mclk_i,
    // control from the block
    input  wire [7:0]  chan_gain_o,
    input  wire        conv_start_o,
    // result to the block
    output reg  [15:0] conv_data_i
);
    reg [7:0] cnt_r;
    initial begin
        cnt_r = 8'h00;
        conv_data_i = 16'hffff;
    end
    // result carries the channel seen at start and a running count
    always @(posedge mclk_i) begin
        if (conv_start_o) begin
            cnt_r <= cnt_r + 8'h01;
            conv_data_i <= {chan_gain_o, cnt_r};
        end
    end
endmodule // adcsq_conv_model

/* test/adcsq_ctrl_test.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
module adcsq_ctrl_test;
    reg         mclk_i;
    reg         rstn_i;
    reg  [7:0]  addr_i;
    reg  [31:0] wdata_i;
    reg         wr_i;
    reg         rd_i;
    reg         ext_trig_i;
    wire [31:0] rdata_o;
    wire [15:0] conv_data_i;
    wire [7:0]  chan_gain_o;
    wire        conv_start_o;
    wire        trig_o;
    wire        trig_oe_n_o;
    wire        irq_o;
    integer     fail_count;
    integer     tests_run;
    integer     cyc;
    integer     n;
    reg  [31:0] d;
    // block and converter model
    adcsq_ctrl #(.TICK_CYCLES(10)) dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .conv_data_i(conv_data_i), .ext_trig_i(ext_trig_i),
        .chan_gain_o(chan_gain_o), .conv_start_o(conv_start_o), .trig_o(trig_o), .trig_oe_n_o(trig_oe_n_o),
        .irq_o(irq_o));
    adcsq_conv_model model (.mclk_i(mclk_i), .chan_gain_o(chan_gain_o), .conv_start_o(conv_start_o),
        .conv_data_i(conv_data_i));
    // clock and cycle count
    always #50 mclk_i = ~mclk_i;
    always @(posedge mclk_i) cyc <= cyc + 1;
    task wr(input [7:0] a, input [31:0] v);
        begin
            @(posedge mclk_i);
            wr_i <= 1'b1;
            addr_i <= a;
            wdata_i <= v;
            @(posedge mclk_i);
            wr_i <= 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge mclk_i);
            rd_i <= 1'b1;
            addr_i <= a;
            @(posedge mclk_i);
            rd_i <= 1'b0;
            #1 d = rdata_o;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // poll status until bit b clears, n gets the cycles spent
    task wait_stat(input integer b);
        integer t0;
        begin
            t0 = cyc;
            rd(8'h08);
            while (d[b] !== 1'b0 && cyc - t0 < 400) rd(8'h08);
            n = cyc - t0;
        end
    endtask
    task give_verdict;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, fail_count);
            if (fail_count == 0 && tests_run > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    task t_reset;
        begin
            rd(8'h08); chk(d, 32'h0000_0000);
            rd(8'h10); chk(d, 32'h0000_0000);
            chk(trig_oe_n_o, 32'h0000_0001);
        end
    endtask
    task t_manual;
        begin
            wr(8'h1c, 32'h0000_0008);
            wr(8'h00, 32'h0000_005a);
            wait_stat(1);
            chk(n >= 156 && n <= 168, 32'h0000_0001);
            chk(d, 32'h0000_0008);
            wr(8'h0c, 32'hffff_ffff);
            wr(8'h00, 32'h0000_00a5);
            wait_stat(0);
            chk(n >= 38 && n <= 50, 32'h0000_0001);
            chk(d, 32'h0000_000e);
            rd(8'h04); chk(d, 32'h0000_5a00);
            wr(8'h08, 32'hffff_fff0);
            rd(8'h08); chk(d, 32'h0000_000e);
            wr(8'h08, 32'h0000_000c);
            rd(8'h08); chk(d, 32'h0000_0002);
            wait_stat(1);
        end
    endtask
    task t_mie;
        begin
            wr(8'h1c, 32'h0000_0009);
            repeat (3) @(posedge mclk_i);
            #1 chk(irq_o, 32'h0000_0001);
            wr(8'h1c, 32'h0000_0008);
            repeat (3) @(posedge mclk_i);
            #1 chk(irq_o, 32'h0000_0000);
            wr(8'h08, 32'h0000_0008);
        end
    endtask
    task t_auto;
        begin
            wr(8'h1c, 32'h0000_000a);
            wr(8'h00, 32'h0000_0033);
            n = 0;
            while (conv_start_o !== 1'b1 && n < 400) begin
                @(posedge mclk_i);
                #1 n = n + 1;
            end
            chk(n >= 156 && n <= 168, 32'h0000_0001);
            rd(8'h08); chk(d[0], 32'h0000_0001);
            wait_stat(0);
            rd(8'h04); chk(d, 32'h0000_3301);
            chk(chan_gain_o, 32'h0000_0033);
            wr(8'h08, 32'h0000_000c);
            wr(8'h1c, 32'h0000_0008);
        end
    endtask
    task t_seq;
        begin
            wr(8'h10, 32'hffff_fffd);
            rd(8'h10); chk(d, 32'h0000_0005);
            wr(8'h0c, 32'h0000_0000);
            rd(8'h08); chk(d, 32'h0000_0000);
            wr(8'h10, 32'h0000_0000);
            wr(8'h1c, 32'h0000_0005);
            wr(8'h10, 32'h0000_0005);
            repeat (4) @(posedge mclk_i);
            rd(8'h10); chk(d, 32'h0000_0004);
            rd(8'h14); chk(d & 32'h0000_0008, 32'h0000_0008);
            chk(irq_o, 32'h0000_0001);
            chk(trig_oe_n_o, 32'h0000_0000);
            wr(8'h14, 32'h0000_000f);
            repeat (3) @(posedge mclk_i);
            #1 chk(irq_o, 32'h0000_0000);
        end
    endtask
    task t_ext;
        begin
            wr(8'h1c, 32'h0000_0008);
            wr(8'h18, 32'h0000_0005);
            wr(8'h10, 32'h0000_0003);
            n = 0;
            repeat (210) begin
                @(posedge mclk_i);
                #1 if (trig_o === 1'b1) n = n + 1;
            end
            chk(n >= 3 && n <= 5, 32'h0000_0001);
            rd(8'h14); chk(d, 32'h0000_0001);
            wr(8'h14, 32'h0000_0001);
            ext_trig_i <= 1'b1;
            repeat (210) @(posedge mclk_i);
            rd(8'h14); chk(d, 32'h0000_0001);
            wr(8'h14, 32'h0000_0001);
            repeat (250) @(posedge mclk_i);
            rd(8'h14); chk(d, 32'h0000_0000);
            wr(8'h10, 32'h0000_0000);
            ext_trig_i <= 1'b0;
        end
    endtask
    // main sequence
    initial begin
        mclk_i = 1'b0;
        rstn_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 32'h0000_0000;
        wr_i = 1'b0;
        rd_i = 1'b0;
        ext_trig_i = 1'b0;
        fail_count = 0;
        tests_run = 0;
        cyc = 0;
        repeat (8) @(posedge mclk_i);
        rstn_i <= 1'b1;
        t_reset;
        t_manual;
        t_mie;
        t_auto;
        t_seq;
        t_ext;
        give_verdict;
    end
    // watchdog against a hang
    initial begin
        #2000000;
        fail_count = fail_count + 1;
        give_verdict;
    end
endmodule // adcsq_ctrl_test
bind adcsq_ctrl adcsq_ctrl_props u_props (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .conv_start_o(conv_start_o), .trig_oe_n_o(trig_oe_n_o),
    .irq_o(irq_o));
